// ===== rtl/plp_pkg.sv
// Shared definitions for the lane map and link power block.
package plp_pkg;

  // Lane width modes.
  typedef enum logic [1:0] {
    PLP_WIDTH_X1,
    PLP_WIDTH_X2,
    PLP_WIDTH_X4
  } plp_width_type;

  // Link power states as seen by this block.
  typedef enum logic [2:0] {
    PLP_PWR_DOWN,
    PLP_PWR_TRAIN,
    PLP_PWR_COMPLIANCE,
    PLP_PWR_L0,
    PLP_PWR_L0S,
    PLP_PWR_L1,
    PLP_PWR_L2
  } plp_power_type;

  // Number of lanes in the shared quad.
  localparam int unsigned LANE_COUNT = 4;
  // Lane positions of each controller.
  localparam int unsigned FIRST_BASE_LANE = 0;
  localparam int unsigned SECOND_BASE_LANE = 2;

  // Core clock and reference figures.
  localparam int unsigned CORE_CLK_MHZ = 125;
  localparam int unsigned OWN_CLK_MHZ = 250;

  // Idle time before a direction enters L0s, in ns, and its cycle count.
  localparam int unsigned L0S_IDLE_NS = 1000;
  localparam int unsigned L0S_IDLE_CYC = (L0S_IDLE_NS * OWN_CLK_MHZ) / 1000;

  // Length of a wake request pulse, in ns, and its cycle count.
  localparam int unsigned WAKE_HOLD_NS = 400;
  localparam int unsigned WAKE_HOLD_CYC = (WAKE_HOLD_NS * OWN_CLK_MHZ) / 1000;

  // One 8b/10b symbol: data byte and control flag.
  typedef struct packed {
    logic isControl;
    logic [7:0] dataByte;
  } plp_symbol_type;

  // Link status from the transmit side of the phy.
  typedef struct packed {
    logic refClkOk;
    logic txPllLocked;
    logic termPresent;
    logic activeReceiver;
  } plp_phy_status_type;

endpackage

// ===== rtl/plp_lane_map.sv
`timescale 1ns/1ps
`default_nettype none
// Steers symbols of both controllers onto the quad lanes by width mode.
module plp_lane_map (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire plp_pkg::plp_width_type widthMode,
  input wire plp_pkg::plp_symbol_type [1:0] firstSym,
  input wire plp_pkg::plp_symbol_type [1:0] secondSym,
  input wire plp_pkg::plp_symbol_type [3:0] wideSym,
  output plp_pkg::plp_symbol_type [3:0] laneSym,
  output logic [3:0] laneActive
);

  // Lane steering is registered so all lanes leave on the same edge.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      laneSym <= '0;
      laneActive <= 4'h0;
    end else begin
      unique case (widthMode)
        plp_pkg::PLP_WIDTH_X1: begin
          // Each controller owns one lane; the others idle.
          laneSym <= '0;
          laneSym[plp_pkg::FIRST_BASE_LANE] <= firstSym[0];
          laneSym[plp_pkg::SECOND_BASE_LANE] <= secondSym[0];
          laneActive <= 4'h5;
        end
        plp_pkg::PLP_WIDTH_X2: begin
          // Lanes 0,1 to the first and 2,3 to the second.
          laneSym <= {secondSym, firstSym};
          laneActive <= 4'hF;
        end
        default: begin
          // One controller spreads its symbols over all lanes.
          laneSym <= wideSym;
          laneActive <= 4'hF;
        end
      endcase
    end
  end

  // x4 must steer all lanes as mapped and x2 lane 3 to the second controller; x1 must declare only lanes 0 and 2 active.
  // The edge that ends reset still loads zeros, so it is left out of each check.
  a_lane_x1_mask: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(widthMode) == plp_pkg::PLP_WIDTH_X1 |-> laneActive == 4'h5)
    else $error("x1 mode did not use lanes 0 and 2");
  a_lane_x2_map: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(widthMode) == plp_pkg::PLP_WIDTH_X2
    |-> laneSym[3] == $past(secondSym[1]))
    else $error("x2 mode lane 3 is not the second controller");
  a_lane_x4_map: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(widthMode) == plp_pkg::PLP_WIDTH_X4 |-> laneSym == $past(wideSym))
    else $error("x4 mode lanes do not follow the wide controller");

endmodule
`default_nettype wire

// ===== rtl/plp_idle_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts idle cycles in one link direction and flags L0s when long enough.
module plp_idle_timer #(
  parameter int unsigned IDLE_CYC = plp_pkg::L0S_IDLE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic busy,
  output logic inIdle
);

  // Counter wide enough for the idle threshold.
  logic [$clog2(IDLE_CYC + 1)-1:0] idleCnt_q;

  // Any traffic or a disabled link restarts the count and leaves L0s.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idleCnt_q <= '0;
      inIdle <= 1'b0;
    end else if (!enable || busy) begin
      idleCnt_q <= '0;
      inIdle <= 1'b0;
    end else if (idleCnt_q == IDLE_CYC[$bits(idleCnt_q)-1:0] - 1'b1) begin
      inIdle <= 1'b1;
    end else begin
      idleCnt_q <= idleCnt_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/plp_link_power.sv
`timescale 1ns/1ps
`default_nettype none
module plp_link_power #(
  parameter int unsigned IDLE_CYC = plp_pkg::L0S_IDLE_CYC,
  parameter int unsigned WAKE_CYC = plp_pkg::WAKE_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic isRootPort,
  input wire logic useBeacon,
  input wire plp_pkg::plp_width_type widthMode,
  input wire plp_pkg::plp_symbol_type [1:0] firstSym,
  input wire plp_pkg::plp_symbol_type [1:0] secondSym,
  input wire plp_pkg::plp_symbol_type [3:0] wideSym,
  input wire plp_pkg::plp_phy_status_type phyStatus,
  input wire logic trainDone,
  input wire logic txBusy,
  input wire logic rxBusy,
  input wire logic partnerL1,
  input wire logic partnerL2,
  input wire logic partnerExitL2,
  input wire logic partnerReady,
  input wire logic turnOffLink,
  input wire logic pmRequest,
  input wire logic beaconSeen,
  input wire logic irqClear,
  output plp_pkg::plp_symbol_type [3:0] laneSym,
  output logic [3:0] laneActive,
  output plp_pkg::plp_power_type powerState,
  output logic linkEnabled,
  output logic txL0s,
  output logic rxL0s,
  output logic pllShutdown,
  output logic beaconTx,
  output logic wakeReq_n,
  output logic powerEventIrqFlag,
  output logic pmIrq
);

  // The whole block runs on core_clk, the clock the phy PLL supplies.

  // Lane steering and striping across the quad.
  plp_lane_map u_lane_map (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .widthMode(widthMode),
    .firstSym(firstSym),
    .secondSym(secondSym),
    .wideSym(wideSym),
    .laneSym(laneSym),
    .laneActive(laneActive)
  );

  // Each direction has its own timer so neither waits on the other.
  logic inL0 ;
  assign inL0 = (powerState == plp_pkg::PLP_PWR_L0) || (powerState == plp_pkg::PLP_PWR_L0S);

  plp_idle_timer #(.IDLE_CYC(IDLE_CYC)) u_tx_idle (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(inL0),
    .busy(txBusy),
    .inIdle(txL0s)
  );

  plp_idle_timer #(.IDLE_CYC(IDLE_CYC)) u_rx_idle (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(inL0),
    .busy(rxBusy),
    .inIdle(rxL0s)
  );

  // True when compliance entry is possible with no receiver present.
  logic complianceCond;
  assign complianceCond = phyStatus.termPresent && phyStatus.refClkOk &&
                          phyStatus.txPllLocked && !phyStatus.activeReceiver;

  // Wake seen by a root port: only the beacon path exists there.
  logic wakeSeen;
  assign wakeSeen = isRootPort && beaconSeen;

  // Marks that the current bring-up came from a wake, for the interrupt.
  // It is cleared once the link is back in L0, so a later plain bring-up
  // after a turn-off command does not raise a stale interrupt.
  logic wokeUp_q;

  // Power state machine; a root port lifts the link out of down at once, an endpoint only on partnerExitL2.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerState <= plp_pkg::PLP_PWR_DOWN;
      linkEnabled <= 1'b0;
    end else begin
      unique case (powerState)
        plp_pkg::PLP_PWR_DOWN: begin
          // An endpoint waits for the partner to train it.
          if (isRootPort || partnerExitL2) begin
            powerState <= plp_pkg::PLP_PWR_TRAIN;
            linkEnabled <= 1'b1;
          end
        end
        plp_pkg::PLP_PWR_TRAIN: begin
          // Receiver detection is skipped; a bare termination goes to compliance.
          if (complianceCond) begin
            powerState <= plp_pkg::PLP_PWR_COMPLIANCE;
          end else if (trainDone) begin
            powerState <= plp_pkg::PLP_PWR_L0;
          end
        end
        plp_pkg::PLP_PWR_COMPLIANCE: begin
          // A real receiver appearing restarts normal training.
          if (phyStatus.activeReceiver) begin
            powerState <= plp_pkg::PLP_PWR_TRAIN;
          end
        end
        plp_pkg::PLP_PWR_L0, plp_pkg::PLP_PWR_L0S: begin
          // A turn-off command outranks every other request, since software
          // has already decided to drop the link and waits only on the partner.
          if (isRootPort && turnOffLink && partnerReady) begin
            powerState <= plp_pkg::PLP_PWR_L2;
            linkEnabled <= 1'b0;
          end else if (!isRootPort && partnerL2) begin
            powerState <= plp_pkg::PLP_PWR_L2;
            linkEnabled <= 1'b0;
          end else if (partnerL1) begin
            // L1 only on the partner's direction.
            powerState <= plp_pkg::PLP_PWR_L1;
          end else begin
            // The state shows L0s only while both directions are idle.
            // Each direction still enters its own idle on its own.
            powerState <= (txL0s && rxL0s) ? plp_pkg::PLP_PWR_L0S : plp_pkg::PLP_PWR_L0;
          end
        end
        plp_pkg::PLP_PWR_L1: begin
          // Leaving L1 is also the partner's call; there is no retrain here.
          if (!partnerL1) begin
            powerState <= plp_pkg::PLP_PWR_L0;
          end
        end
        plp_pkg::PLP_PWR_L2: begin
          // L2 holds until a wake or the partner/command lifts it.
          if (isRootPort && (!turnOffLink || wakeSeen)) begin
            powerState <= plp_pkg::PLP_PWR_TRAIN;
            linkEnabled <= 1'b1;
          end else if (!isRootPort && partnerExitL2) begin
            powerState <= plp_pkg::PLP_PWR_TRAIN;
            linkEnabled <= 1'b1;
          end
        end
      endcase
    end
  end

  // The phy PLL is shut down while in L1.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pllShutdown <= 1'b0;
    end else begin
      pllShutdown <= (powerState == plp_pkg::PLP_PWR_L1) && partnerL1;
    end
  end

  // Endpoint wake signalling; the pulse is stretched so the host sees it.
  logic [$clog2(WAKE_CYC + 1)-1:0] wakeCnt_q;
  logic wakeStart;
  assign wakeStart = !isRootPort && pmRequest && powerState == plp_pkg::PLP_PWR_L2;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeCnt_q <= '0;
    end else if (wakeStart && wakeCnt_q == '0) begin
      wakeCnt_q <= WAKE_CYC[$bits(wakeCnt_q)-1:0];
    end else if (wakeCnt_q != '0) begin
      wakeCnt_q <= wakeCnt_q - 1'b1;
    end
  end

  // The chosen wake method drives either the beacon or the low-true pin.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beaconTx <= 1'b0;
      wakeReq_n <= 1'b1;
    end else begin
      beaconTx <= (wakeCnt_q != '0) && useBeacon;
      wakeReq_n <= !((wakeCnt_q != '0) && !useBeacon);
    end
  end

  // Remember that a wake caused the bring-up until the link is up again.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wokeUp_q <= 1'b0;
    end else if (powerState == plp_pkg::PLP_PWR_L2 && wakeSeen) begin
      wokeUp_q <= 1'b1;
    end else if (powerState == plp_pkg::PLP_PWR_L0) begin
      wokeUp_q <= 1'b0;
    end
  end

  // One-cycle interrupt once the woken link is back in L0.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pmIrq <= 1'b0;
    end else begin
      pmIrq <= wokeUp_q && powerState == plp_pkg::PLP_PWR_L0;
    end
  end

  // Sticky power event flag; a new event wins over a clear in the same cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerEventIrqFlag <= 1'b0;
    end else if (isRootPort && (pmRequest || beaconSeen)) begin
      powerEventIrqFlag <= 1'b1;
    end else if (irqClear) begin
      powerEventIrqFlag <= 1'b0;
    end
  end

  // The lock-select bit is kept by outside logic, keyed on powerState.

  a_comp_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
    powerState == plp_pkg::PLP_PWR_TRAIN && complianceCond
    |=> powerState == plp_pkg::PLP_PWR_COMPLIANCE)
    else $error("compliance not entered");
  a_ep_no_bringup: assert property (@(posedge core_clk) disable iff (sys_rst)
    !isRootPort && powerState == plp_pkg::PLP_PWR_DOWN && !partnerExitL2
    |=> !linkEnabled)
    else $error("endpoint enabled link alone");
  a_l2_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    powerState == plp_pkg::PLP_PWR_L2 && isRootPort && turnOffLink && !beaconSeen
    |=> powerState == plp_pkg::PLP_PWR_L2)
    else $error("root left L2 without cause");
  a_turn_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    isRootPort && powerState == plp_pkg::PLP_PWR_L0 && turnOffLink && partnerReady
    |=> powerState == plp_pkg::PLP_PWR_L2 && !linkEnabled)
    else $error("turn-off did not reach L2");
  a_wake_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
    wakeStart && wakeCnt_q == '0 && !useBeacon ##1 !useBeacon |=> !wakeReq_n)
    else $error("wake pin not driven low");
  a_ep_l2_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
    !isRootPort && powerState == plp_pkg::PLP_PWR_L0 && partnerL2
    |=> powerState == plp_pkg::PLP_PWR_L2)
    else $error("endpoint ignored L2 direction");
  a_root_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    isRootPort && powerState == plp_pkg::PLP_PWR_L2 && beaconSeen |=> linkEnabled)
    else $error("root did not wake link");
  a_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    isRootPort && pmRequest |=> powerEventIrqFlag)
    else $error("power event flag not set");

  // The PLL must be off the cycle after L1 is held with the partner still idle.
  a_pll_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    powerState == plp_pkg::PLP_PWR_L1 && partnerL1 |=> pllShutdown)
    else $error("pll not shut down in L1");

  // Clearing the turn-off command must bring a root port out of L2.
  a_turn_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    isRootPort && powerState == plp_pkg::PLP_PWR_L2 && !turnOffLink
    |=> powerState == plp_pkg::PLP_PWR_TRAIN && linkEnabled)
    else $error("root did not leave L2 on command clear");

  // An endpoint in L2 leaves only when its partner says so.
  a_ep_l2_exit: assert property (@(posedge core_clk) disable iff (sys_rst)
    !isRootPort && powerState == plp_pkg::PLP_PWR_L2 && !partnerExitL2
    |=> powerState == plp_pkg::PLP_PWR_L2)
    else $error("endpoint left L2 on its own");

  // A woken link back in L0 must raise the interrupt on the next edge.
  a_wake_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
    wokeUp_q && powerState == plp_pkg::PLP_PWR_L0 |=> pmIrq)
    else $error("no interrupt after wake");

  // Traffic in one direction must end that direction's idle state only.
  a_tx_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
    txBusy |=> !txL0s)
    else $error("tx idle held while busy");
  a_rx_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
    rxBusy |=> !rxL0s)
    else $error("rx idle held while busy");

endmodule
`default_nettype wire

// ===== test/plp_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// Link partner model: turns bench commands into registered partner indications.
module plp_partner_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire plp_pkg::plp_power_type powerState,
  input wire logic readyEn,
  input wire logic l1Cmd,
  input wire logic l2Cmd,
  input wire logic exitCmd,
  input wire logic beaconCmd,
  output logic trainDone,
  output logic partnerReady,
  output logic partnerL1,
  output logic partnerL2,
  output logic partnerExitL2,
  output logic beaconSeen,
  output logic rxPllLockSelect
);
  // Cycles spent in training; slow mode stretches it to test a late answer.
  logic [3:0] trainCnt_q;

  // Training completes only after the chosen delay, never instantly.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trainCnt_q <= 4'h0;
    end else if (powerState == plp_pkg::PLP_PWR_TRAIN) begin
      trainCnt_q <= trainCnt_q + 4'h1;
    end else begin
      trainCnt_q <= 4'h0;
    end
  end
  assign trainDone = (powerState == plp_pkg::PLP_PWR_TRAIN) && (trainCnt_q >= (slow ? 4'h6 : 4'h1));

  // Partner indications follow the commands one cycle late, as a real port would.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      partnerReady <= 1'b0;
      partnerL1 <= 1'b0;
      partnerL2 <= 1'b0;
      partnerExitL2 <= 1'b0;
      beaconSeen <= 1'b0;
    end else begin
      partnerReady <= readyEn;
      partnerL1 <= l1Cmd;
      partnerL2 <= l2Cmd;
      partnerExitL2 <= exitCmd;
      beaconSeen <= beaconCmd;
    end
  end

  // Lock select is cleared only while the device sits in compliance.
  assign rxPllLockSelect = (powerState != plp_pkg::PLP_PWR_COMPLIANCE);
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the lane map and link power block.
module tb;
  // One expected result with the window of cycles in which it must show.
  typedef struct {int id; logic [39:0] exp; int lo; int hi; string nm;} plp_note_type;
  plp_note_type notes[$];
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic isRootPort = 1'b1;
  logic useBeacon = 1'b0;
  plp_pkg::plp_width_type widthMode = plp_pkg::PLP_WIDTH_X1;
  plp_pkg::plp_symbol_type [1:0] firstSym = '0;
  plp_pkg::plp_symbol_type [1:0] secondSym = '0;
  plp_pkg::plp_symbol_type [3:0] wideSym = '0;
  plp_pkg::plp_phy_status_type phyStatus = 4'hF;
  logic txBusy = 1'b1;
  logic rxBusy = 1'b1;
  logic turnOffLink = 1'b0;
  logic pmRequest = 1'b0;
  logic irqClear = 1'b0;
  logic slow = 1'b0;
  logic readyEn = 1'b0;
  logic l1Cmd = 1'b0;
  logic l2Cmd = 1'b0;
  logic exitCmd = 1'b0;
  logic beaconCmd = 1'b0;
  logic trainDone, partnerReady, partnerL1, partnerL2, partnerExitL2, beaconSeen;
  plp_pkg::plp_symbol_type [3:0] laneSym;
  logic [3:0] laneActive;
  plp_pkg::plp_power_type powerState;
  logic linkEnabled, txL0s, rxL0s, pllShutdown, beaconTx, wakeReq_n, powerEventIrqFlag, pmIrq;
  int cyc = 0;
  int errors = 0;
  int totalChecks = 0;
  logic [31:0] rnd = 32'h0000E4EE;

  // Short counts keep the run brief; expectations use the same figures.
  plp_link_power #(.IDLE_CYC(4), .WAKE_CYC(3)) plp_link_power_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .isRootPort(isRootPort), .useBeacon(useBeacon), .widthMode(widthMode),
    .firstSym(firstSym), .secondSym(secondSym), .wideSym(wideSym), .phyStatus(phyStatus),
    .trainDone(trainDone), .txBusy(txBusy), .rxBusy(rxBusy), .partnerL1(partnerL1),
    .partnerL2(partnerL2), .partnerExitL2(partnerExitL2), .partnerReady(partnerReady),
    .turnOffLink(turnOffLink), .pmRequest(pmRequest), .beaconSeen(beaconSeen),
    .irqClear(irqClear), .laneSym(laneSym), .laneActive(laneActive), .powerState(powerState),
    .linkEnabled(linkEnabled), .txL0s(txL0s), .rxL0s(rxL0s), .pllShutdown(pllShutdown),
    .beaconTx(beaconTx), .wakeReq_n(wakeReq_n), .powerEventIrqFlag(powerEventIrqFlag),
    .pmIrq(pmIrq));

  plp_partner_model plp_partner_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
    .powerState(powerState), .readyEn(readyEn), .l1Cmd(l1Cmd), .l2Cmd(l2Cmd),
    .exitCmd(exitCmd), .beaconCmd(beaconCmd), .trainDone(trainDone),
    .partnerReady(partnerReady), .partnerL1(partnerL1), .partnerL2(partnerL2),
    .partnerExitL2(partnerExitL2), .beaconSeen(beaconSeen), .rxPllLockSelect());

  // A 4 ns clock and a cycle count that the notes are timed against.
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  // Picks the output group that a note refers to.
  function automatic logic [39:0] seen(int id);
    case (id)
      0: return {laneSym, laneActive};
      1: return 40'(powerState);
      2: return 40'(linkEnabled);
      3: return 40'({txL0s, rxL0s});
      4: return 40'(pllShutdown);
      5: return 40'({beaconTx, wakeReq_n});
      6: return 40'(powerEventIrqFlag);
      default: return 40'(pmIrq);
    endcase
  endfunction

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Watches outputs at the falling edge, where they are settled, oldest note first.
  always @(negedge core_clk) begin
    if (notes.size() > 0 && cyc >= notes[0].lo) begin
      if (seen(notes[0].id) === notes[0].exp) begin
        totalChecks++;
        void'(notes.pop_front());
      end else if (cyc >= notes[0].hi) begin
        totalChecks++;
        errors++;
        $display("ERROR %s expected %0h seen %0h", notes[0].nm, notes[0].exp, seen(notes[0].id));
        void'(notes.pop_front());
      end
    end
  end

  task automatic note(int id, logic [39:0] e, int lo, int hi, string nm);
    notes.push_back('{id, e, cyc + lo, cyc + hi, nm});
  endtask

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Waits for all notes to be judged; a stuck note ends the run.
  task automatic settle(string test);
    int i;
    for (i = 0; i < 500 && notes.size() > 0; i++) @(posedge core_clk);
    if (notes.size() > 0) begin
      errors++;
      $display("ERROR %s expected notes done seen %0d left", test, notes.size());
      wrapUp();
    end
    $display("test %s done", test);
  endtask

  task automatic doReset(logic root, logic slowMode);
    sys_rst <= 1'b1;
    isRootPort <= root;
    slow <= slowMode;
    step(4);
    sys_rst <= 1'b0;
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence: lanes, root power flow, compliance, endpoint wake.
  initial begin
    int m;
    logic [35:0] e;
    step(4);
    sys_rst <= 1'b0;
    for (m = 0; m < 3; m++) begin
      repeat (4) begin
        @(posedge core_clk);
        rnd = lfsr(lfsr(rnd));
        widthMode <= plp_pkg::plp_width_type'(m);
        firstSym <= rnd[17:0];
        secondSym <= rnd[31:14];
        wideSym <= {rnd, rnd[7:4]};
        e = (m == 0) ? {9'h000, rnd[22:14], 9'h000, rnd[8:0]} :
            (m == 1) ? {rnd[31:14], rnd[17:0]} : {rnd, rnd[7:4]};
        note(0, {e, (m == 0) ? 4'h5 : 4'hF}, 2, 2, "laneMap");
      end
    end
    settle("lanes");
    note(2, 40'h1, 0, 60, "linkEnabled");
    note(1, 40'(plp_pkg::PLP_PWR_L0), 0, 60, "powerState");
    settle("rootUp");
    @(posedge core_clk);
    txBusy <= 1'b0;
    rxBusy <= 1'b0;
    note(3, 40'h3, 1, 12, "l0sBoth");
    note(1, 40'(plp_pkg::PLP_PWR_L0S), 0, 8, "powerState");
    settle("l0sIdle");
    txBusy <= 1'b1;
    note(3, 40'h1, 1, 4, "l0sRxOnly");
    settle("l0sSplit");
    rxBusy <= 1'b1;
    turnOffLink <= 1'b1;
    readyEn <= 1'b1;
    note(1, 40'(plp_pkg::PLP_PWR_L2), 1, 30, "powerState");
    note(2, 40'h0, 0, 30, "linkEnabled");
    settle("turnOff");
    readyEn <= 1'b0;
    note(1, 40'(plp_pkg::PLP_PWR_L2), 12, 12, "powerState");
    settle("holdL2");
    beaconCmd <= 1'b1;
    step(1);
    beaconCmd <= 1'b0;
    note(1, 40'(plp_pkg::PLP_PWR_L0), 1, 60, "powerState");
    note(7, 40'h1, 0, 2, "pmIrq");
    note(6, 40'h1, 0, 2, "irqFlag");
    settle("beaconWake");
    irqClear <= 1'b1;
    step(1);
    irqClear <= 1'b0;
    note(6, 40'h0, 1, 3, "irqFlag");
    settle("irqClear");
    readyEn <= 1'b1;
    note(1, 40'(plp_pkg::PLP_PWR_L2), 1, 30, "powerState");
    settle("turnOff2");
    turnOffLink <= 1'b0;
    readyEn <= 1'b0;
    note(2, 40'h1, 1, 60, "linkEnabled");
    note(1, 40'(plp_pkg::PLP_PWR_L0), 0, 60, "powerState");
    settle("turnOn");
    l1Cmd <= 1'b1;
    note(1, 40'(plp_pkg::PLP_PWR_L1), 1, 20, "powerState");
    note(4, 40'h1, 0, 4, "pllShutdown");
    settle("enterL1");
    l1Cmd <= 1'b0;
    phyStatus <= 4'hE;
    doReset(1'b1, 1'b1);
    note(1, 40'(plp_pkg::PLP_PWR_COMPLIANCE), 1, 30, "powerState");
    settle("compliance");
    phyStatus <= 4'hF;
    note(1, 40'(plp_pkg::PLP_PWR_L0), 1, 60, "powerState");
    settle("activeRx");
    doReset(1'b0, 1'b0);
    note(2, 40'h0, 20, 20, "linkEnabled");
    settle("endpointDown");
    exitCmd <= 1'b1;
    step(1);
    exitCmd <= 1'b0;
    note(1, 40'(plp_pkg::PLP_PWR_L0), 1, 60, "powerState");
    settle("endpointUp");
    l2Cmd <= 1'b1;
    note(1, 40'(plp_pkg::PLP_PWR_L2), 1, 20, "powerState");
    settle("endpointL2");
    l2Cmd <= 1'b0;
    for (m = 0; m < 2; m++) begin
      useBeacon <= m[0];
      pmRequest <= 1'b1;
      step(1);
      pmRequest <= 1'b0;
      note(5, (m == 0) ? 40'h0 : 40'h3, 1, 4, "wakeSignal");
      note(5, 40'h1, 1, 8, "wakeIdle");
      settle("wake");
    end
    exitCmd <= 1'b1;
    step(1);
    exitCmd <= 1'b0;
    note(1, 40'(plp_pkg::PLP_PWR_L0), 1, 60, "powerState");
    settle("endpointExit");
    wrapUp();
  end
endmodule
`default_nettype wire
